//--- verilog/uv_fault_pkg.sv
package uv_fault_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_UV_FAULT_THRESHOLD = 8'h44; // Word command
  localparam logic [7:0] CMD_UV_FAULT_ACTION    = 8'h45; // Byte command
  localparam logic [7:0] CMD_CLEAR_FAULTS       = 8'h03; // Send-byte, no data

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] UV_THRESHOLD_RESET = 16'h0000; // Never trips until programmed
  localparam logic [7:0]  UV_ACTION_RESET    = 8'h00;    // Ignore fault

  // ----------------------------------------------------------------
  // Action byte field positions
  // ----------------------------------------------------------------
  localparam int RESPONSE_MSB = 7;
  localparam int RESPONSE_LSB = 6;
  localparam int RETRIES_MSB  = 5;
  localparam int RETRIES_LSB  = 3;
  localparam int DELAY_MSB    = 2;
  localparam int DELAY_LSB    = 0;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_IGNORE     = 2'h0;
  localparam logic [1:0] RESP_DELAY_RUN  = 2'h1;
  localparam logic [1:0] RESP_DISABLE    = 2'h2;
  localparam logic [1:0] RESP_HOLD_OFF   = 2'h3;
  localparam logic [2:0] RETRY_NONE      = 3'h0;
  localparam logic [2:0] RETRY_ENDLESS   = 3'h7;

  // Command request from the PMBus front end, one cycle per command
  typedef struct packed {
    logic        valid; // Request strobe
    logic        write; // 1 write, 0 read
    logic [7:0]  code;  // Command code
    logic [15:0] wdata; // Write data, byte commands use low byte
  } cmd_req_type;

  // Decoded action byte
  typedef struct packed {
    logic [1:0] response;
    logic [2:0] retries;
    logic [2:0] delay;
  } uv_action_type;

endpackage : uv_fault_pkg

//--- verilog/uv_compare.sv
`timescale 1ns/1ps
module uv_compare
  import uv_fault_pkg::*;
(
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Synchronous reset
  input  wire logic        ce_i,        // Clock enable
  input  wire logic [15:0] vout_i,      // Output voltage sample
  input  wire logic        vout_valid_i, // Sample strobe
  input  wire logic [15:0] threshold_i, // Undervoltage threshold
  output logic             uv_o         // Below threshold, held between samples
);

  // ----------------------------------------------------------------
  // Compare each new sample, unsigned as the data format asks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uv_o <= 1'b0;
    end else if (ce_i && vout_valid_i) begin
      uv_o <= (vout_i < threshold_i); // [RQ1]
    end
  end

endmodule : uv_compare

//--- verilog/uv_delay_timer.sv
`timescale 1ns/1ps
module uv_delay_timer
  import uv_fault_pkg::*;
(
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_i,   // Synchronous reset
  input  wire logic       ce_i,    // Clock enable
  input  wire logic       start_i, // Restart the interval
  input  wire logic [2:0] code_i,  // Delay code, 2**code units
  input  wire logic       tick_i,  // One pulse per delay unit
  output logic            done_o   // One-cycle pulse at expiry
);

  logic [7:0] units;  // Units to wait, latched at start
  logic [7:0] count;  // Units seen so far
  logic       busy;   // Interval running

  // ----------------------------------------------------------------
  // Interval counter; a new start always restarts from zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      units  <= 8'h00;
      count  <= 8'h00;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i) begin
        units <= 8'h01 << code_i; // [RQ12]
        count <= 8'h00;
        busy  <= 1'b1;
      end else if (busy && tick_i) begin
        // Compare before the increment so 128 fits in eight bits
        if (count == units - 8'h01) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count + 8'h01;
        end
      end
    end
  end

endmodule : uv_delay_timer

//--- verilog/uv_fault_handler.sv
// Contract
// RQ1: Sixteen-bit read/write unsigned undervoltage threshold word.
// RQ2: Read/write action byte selects undervoltage reaction.
// RQ3: Response 00 keeps running, no action.
// RQ4: Response 01 runs for delay, then retries.
// RQ5: Response 10 disables at once, then retries.
// RQ6: Response 11 holds off while undervoltage persists.
// RQ7: Bit clear, clear command, reset, off-on clear.
// RQ8: Retry 000 stays off until cleared.
// RQ9: Retry 111 restarts endlessly until commanded off.
// RQ10: Retry 001 one attempt, spaced by delay.
// RQ11: Retry 010 to 110 give two to six.
// RQ12: Delay code gives 1 to 128 units.
// RQ13: Attempt counter resets on clear or enable.
`timescale 1ns/1ps
module uv_fault_handler
  import uv_fault_pkg::*;
(
  input  wire logic        clk_i,            // System clock, 100 MHz
  input  wire logic        rst_i,            // Synchronous reset, bias-power reset
  input  wire logic        ce_i,             // Clock enable, freezes all state
  input  wire cmd_req_type cmd_i,            // Decoded command from front end
  input  wire logic [15:0] vout_i,           // Output voltage sample
  input  wire logic        vout_valid_i,     // Sample strobe
  input  wire logic        delay_tick_i,     // One pulse per delay unit
  input  wire logic        output_on_i,      // Output commanded on
  input  wire logic        fault_bit_clear_i, // Status bit cleared by host
  output logic             cmd_ack_o,        // Answer strobe for any command
  output logic [15:0]      cmd_rdata_o,      // Read data, zero for unknown codes
  output logic             out_enable_o,     // Power stage enable
  output logic             uv_fault_o,       // Fault being handled or latched
  output logic             uv_level_o        // Undervoltage seen now
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN       = 3'b000, // Normal operation
    ST_DELAY_RUN = 3'b001, // Still running, delay before acting
    ST_HOLD      = 3'b010, // Off while undervoltage present
    ST_OFF_WAIT  = 3'b011, // Off, waiting before next attempt
    ST_RESTART   = 3'b100, // Attempt in progress, output on
    ST_LATCHED   = 3'b101  // Off until cleared
  } state_type;

  logic [15:0]   threshold;     // Threshold word
  logic [7:0]    action_byte;   // Raw action byte
  uv_action_type action;        // Field view of the action byte
  state_type     state;         // Current handler state
  state_type     next_state;    // Next handler state
  logic [2:0]    attempts;      // Restart attempts made
  logic [2:0]    next_attempts; // Next attempt count
  logic          timer_start;   // Restart the delay interval
  logic          timer_done;    // Delay interval expired
  logic          uv;            // Compared undervoltage level
  logic          clear_evt;     // Bit clear, output off or clear command
  logic          more_tries;    // Another restart allowed

  assign action = uv_action_type'(action_byte);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  uv_compare u_compare (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .vout_i       (vout_i),
    .vout_valid_i (vout_valid_i),
    .threshold_i  (threshold),
    .uv_o         (uv)
  );

  uv_delay_timer u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .start_i (timer_start),
    .code_i  (action.delay),
    .tick_i  (delay_tick_i),
    .done_o  (timer_done)
  );

  // ----------------------------------------------------------------
  // Command port
  // ----------------------------------------------------------------
  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      threshold   <= UV_THRESHOLD_RESET;
      action_byte <= UV_ACTION_RESET;
    end else if (ce_i && cmd_i.valid && cmd_i.write) begin
      if (cmd_i.code == CMD_UV_FAULT_THRESHOLD) begin
        threshold <= cmd_i.wdata; // [RQ1]
      end
      if (cmd_i.code == CMD_UV_FAULT_ACTION) begin
        action_byte <= cmd_i.wdata[7:0]; // [RQ2]
      end
    end
  end

  // Read answers, one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ack_o   <= 1'b0;
      cmd_rdata_o <= 16'h0000;
    end else if (ce_i) begin
      cmd_ack_o <= cmd_i.valid;
      if (cmd_i.valid && !cmd_i.write) begin
        unique case (cmd_i.code)
          CMD_UV_FAULT_THRESHOLD: cmd_rdata_o <= threshold;           // [RQ1]
          CMD_UV_FAULT_ACTION:    cmd_rdata_o <= {8'h00, action_byte}; // [RQ2]
          default:                cmd_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault handling
  // ----------------------------------------------------------------
  // Output off alone clears, so off then on always starts fresh
  assign clear_evt = fault_bit_clear_i || !output_on_i ||
                     (cmd_i.valid && cmd_i.write && cmd_i.code == CMD_CLEAR_FAULTS); // [RQ7]

  // Endless code never runs out; others count up to the code
  assign more_tries = (action.retries == RETRY_ENDLESS) ||
                      (attempts < action.retries); // [RQ9] [RQ10] [RQ11]

  // Next state and attempt count
  always_comb begin
    next_state    = state;
    next_attempts = attempts;
    timer_start   = 1'b0;
    if (clear_evt) begin
      // Clear wins over every state; a live fault re-enters next cycle
      next_state    = ST_RUN;         // [RQ7]
      next_attempts = 3'h0;           // [RQ13]
    end else begin
      unique case (state)
        ST_RUN: begin
          next_attempts = 3'h0;       // [RQ13]
          if (uv) begin
            unique case (action.response)
              RESP_IGNORE: next_state = ST_RUN; // [RQ3]
              RESP_DELAY_RUN: begin
                next_state  = ST_DELAY_RUN;     // [RQ4]
                timer_start = 1'b1;
              end
              RESP_DISABLE: begin
                // No retries means straight to the latched state
                if (action.retries == RETRY_NONE) begin
                  next_state = ST_LATCHED;      // [RQ5] [RQ8]
                end else begin
                  next_state  = ST_OFF_WAIT;    // [RQ5]
                  timer_start = 1'b1;
                end
              end
              RESP_HOLD_OFF: next_state = ST_HOLD; // [RQ6]
            endcase
          end
        end
        ST_DELAY_RUN: begin
          // Only the level at expiry matters
          if (timer_done) begin
            if (!uv) begin
              next_state = ST_RUN;
            end else if (action.retries == RETRY_NONE) begin
              next_state = ST_LATCHED;  // [RQ4] [RQ8]
            end else begin
              next_state  = ST_OFF_WAIT; // [RQ4]
              timer_start = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (!uv) begin
            next_state = ST_RUN;        // [RQ6]
          end
        end
        ST_OFF_WAIT: begin
          if (timer_done) begin
            next_state    = ST_RESTART; // [RQ10]
            next_attempts = (attempts == RETRY_ENDLESS) ? attempts : attempts + 3'h1;
            timer_start   = 1'b1;
          end
        end
        ST_RESTART: begin
          // Attempt judged at the end of one delay interval
          if (timer_done) begin
            if (!uv) begin
              next_state = ST_RUN;
            end else if (more_tries) begin
              next_state  = ST_OFF_WAIT; // [RQ9] [RQ11]
              timer_start = 1'b1;
            end else begin
              next_state = ST_LATCHED;   // [RQ10] [RQ11]
            end
          end
        end
        ST_LATCHED: next_state = ST_LATCHED; // [RQ8]
        default:    next_state = ST_RUN;
      endcase
    end
  end

  // State and counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_RUN;             // [RQ7]
      attempts <= 3'h0;
    end else if (ce_i) begin
      state    <= next_state;
      attempts <= next_attempts;
    end
  end

  // Registered outputs; enable and fault taken from the next state so they match it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_enable_o <= 1'b0;
      uv_fault_o   <= 1'b0;
      uv_level_o   <= 1'b0;
    end else if (ce_i) begin
      out_enable_o <= output_on_i && (next_state == ST_RUN ||
                      next_state == ST_DELAY_RUN || next_state == ST_RESTART); // [RQ5] [RQ6]
      uv_fault_o   <= (next_state != ST_RUN);
      uv_level_o   <= uv;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_fault_seen;
    ce_i && state == ST_RUN && uv && !clear_evt;
  endsequence

  property p_threshold_readback;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && cmd_i.valid && cmd_i.write && cmd_i.code == CMD_UV_FAULT_THRESHOLD ##1
    ce_i && cmd_i.valid && !cmd_i.write && cmd_i.code == CMD_UV_FAULT_THRESHOLD
    |=> cmd_ack_o && cmd_rdata_o == $past(cmd_i.wdata, 2);
  endproperty
  a_threshold_readback: assert property (p_threshold_readback) // [RQ1]
    else $error("threshold read does not return written word");

  property p_action_upper_zero;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && cmd_i.valid && !cmd_i.write && cmd_i.code == CMD_UV_FAULT_ACTION
    |=> cmd_rdata_o == {8'h00, action_byte};
  endproperty
  a_action_upper_zero: assert property (p_action_upper_zero) // [RQ2]
    else $error("action byte read is wrong");

  property p_ignore_keeps_on;
    @(posedge clk_i) disable iff (rst_i)
    s_fault_seen and action.response == RESP_IGNORE && output_on_i
    |=> out_enable_o && !uv_fault_o;
  endproperty
  a_ignore_keeps_on: assert property (p_ignore_keeps_on) // [RQ3]
    else $error("ignored fault changed the output");

  property p_delay_keeps_on;
    @(posedge clk_i) disable iff (rst_i)
    s_fault_seen and action.response == RESP_DELAY_RUN && output_on_i
    |=> out_enable_o && state == ST_DELAY_RUN;
  endproperty
  a_delay_keeps_on: assert property (p_delay_keeps_on) // [RQ4]
    else $error("delayed response did not keep running");

  property p_disable_now;
    @(posedge clk_i) disable iff (rst_i)
    s_fault_seen and action.response == RESP_DISABLE |=> !out_enable_o && uv_fault_o;
  endproperty
  a_disable_now: assert property (p_disable_now) // [RQ5]
    else $error("disable response left output on");

  property p_hold_resumes;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && state == ST_HOLD && !uv && output_on_i && !fault_bit_clear_i
    |=> out_enable_o ##0 state == ST_RUN;
  endproperty
  a_hold_resumes: assert property (p_hold_resumes) // [RQ6]
    else $error("hold did not resume when fault went away");

  property p_clear_returns;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && clear_evt |=> state == ST_RUN && attempts == 3'h0;
  endproperty
  a_clear_returns: assert property (p_clear_returns) // [RQ7]
    else $error("clear did not return to run");

  property p_latched_stays_off;
    @(posedge clk_i) disable iff (rst_i)
    state == ST_LATCHED && !clear_evt |=> !out_enable_o ##0 state == ST_LATCHED;
  endproperty
  a_latched_stays_off: assert property (p_latched_stays_off) // [RQ8]
    else $error("latched fault left its state without clear");

  property p_attempt_limit;
    @(posedge clk_i) disable iff (rst_i)
    action.retries != RETRY_ENDLESS |-> attempts <= action.retries || state == ST_RUN;
  endproperty
  a_attempt_limit: assert property (p_attempt_limit) // [RQ11]
    else $error("too many restart attempts");

endmodule : uv_fault_handler

//--- dv/supply_model.sv
`timescale 1ns/1ps
module supply_model
  import uv_fault_pkg::*;
#(
  parameter int SAMPLE_P = 4, // Cycles between voltage samples
  parameter int TICK_P   = 8  // Cycles per delay time unit
)
(
  input  wire logic        clk_i,        // System clock
  input  wire logic [15:0] level_i,      // Output voltage to report
  output logic [15:0]      vout_o,       // Sample bus
  output logic             vout_valid_o, // Sample strobe
  output logic             delay_tick_o  // Delay unit tick
);
  int unsigned cyc; // Free-running phase counter

  // ------------------------------------------------------------
  // Sampler and unit timer, driven off the falling edge
  // ------------------------------------------------------------
  initial begin
    cyc          = 0;
    vout_o       = 16'h0000;
    vout_valid_o = 1'b0;
    delay_tick_o = 1'b0;
  end

  // Sample bus shows junk between strobes so stale data never matches
  always @(negedge clk_i) begin
    cyc          <= cyc + 1;
    vout_valid_o <= (cyc % SAMPLE_P) == 0;
    delay_tick_o <= (cyc % TICK_P) == 1;
    vout_o       <= ((cyc % SAMPLE_P) == 0) ? level_i : ~level_i;
  end
endmodule : supply_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
  import uv_fault_pkg::*;
;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_i             = 1'b0;
  logic        rst_i             = 1'b1;
  logic        ce_i              = 1'b1;     // Dropped only in the freeze check
  cmd_req_type cmd_i             = '0;
  logic [15:0] level             = 16'hFFFF; // Healthy output to start
  logic        output_on_i       = 1'b1;
  logic        fault_bit_clear_i = 1'b0;
  logic [15:0] vout_i;
  logic        vout_valid_i;
  logic        delay_tick_i;
  logic        cmd_ack_o;
  logic [15:0] cmd_rdata_o;
  logic        out_enable_o;
  logic        uv_fault_o;
  logic        uv_level_o;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  initial forever #5 clk_i = ~clk_i;

  supply_model sup (.clk_i(clk_i), .level_i(level), .vout_o(vout_i),
    .vout_valid_o(vout_valid_i), .delay_tick_o(delay_tick_i));

  uv_fault_handler dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmd_i(cmd_i),
    .vout_i(vout_i), .vout_valid_i(vout_valid_i), .delay_tick_i(delay_tick_i),
    .output_on_i(output_on_i), .fault_bit_clear_i(fault_bit_clear_i),
    .cmd_ack_o(cmd_ack_o), .cmd_rdata_o(cmd_rdata_o), .out_enable_o(out_enable_o),
    .uv_fault_o(uv_fault_o), .uv_level_o(uv_level_o));

  // ------------------------------------------------------------
  // Command port helpers
  // ------------------------------------------------------------
  // One request, answer looked at the cycle its strobe stands
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                     output logic [15:0] rd);
    @(negedge clk_i);
    cmd_i = '{1'b1, w, c, d};
    @(negedge clk_i);
    cmd_i = '0;
    // Answer stands only in the cycle after the request edge
    `CHK("cmd_ack_o", 1'b1, cmd_ack_o)
    rd = cmd_rdata_o;
  endtask : cmd

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] unused;
    cmd(1'b1, c, d, unused);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] c, input logic [15:0] ex);
    logic [15:0] v;
    cmd(1'b0, c, 16'h0000, v);
    `CHK(nm, ex, v)
  endtask : rdchk

  // ------------------------------------------------------------
  // Bounded waits and measurements
  // ------------------------------------------------------------
  task automatic wait_en(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && out_enable_o !== v; i++) @(negedge clk_i);
    if (out_enable_o !== v) begin
      n_mismatch++;
      $display("Error out_enable_o expected %0h seen %0h", v, out_enable_o);
      conclude();
    end
  endtask : wait_en

  // Cycles from undervoltage seen to output dropped
  task automatic lat(output int k);
    int i;
    for (i = 0; i < 400 && uv_level_o !== 1'b1; i++) @(negedge clk_i);
    for (k = 0; k < 2000 && out_enable_o !== 1'b0; k++) @(negedge clk_i);
    // Output never dropped: count it and stop the run
    if (out_enable_o !== 1'b0) begin
      n_mismatch++;
      $display("Error out_enable_o expected 0 seen %0h", out_enable_o);
      conclude();
    end
  endtask : lat

  // Counts restart attempts as rising edges of the enable
  task automatic restarts(input int win, output int k);
    logic p;
    p = out_enable_o;
    k = 0;
    repeat (win) begin
      @(negedge clk_i);
      if (out_enable_o === 1'b1 && p !== 1'b1) k++;
      p = out_enable_o;
    end
  endtask : restarts

  // Healthy voltage, then the clear command
  task automatic clr();
    level = 16'hFFFF;
    // Let a fresh sample drop the level first, or the clear re-enters the fault
    repeat (8) @(negedge clk_i);
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    wait_en(1'b1, 60);
  endtask : clr

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rdchk("thr_reset", CMD_UV_FAULT_THRESHOLD, 16'h0000);
    rdchk("act_reset", CMD_UV_FAULT_ACTION, 16'h0000);
    wr(CMD_UV_FAULT_THRESHOLD, 16'hA5C3);
    wr(CMD_UV_FAULT_ACTION, 16'hFF96);
    rdchk("thr_rw", CMD_UV_FAULT_THRESHOLD, 16'hA5C3);
    rdchk("act_rw", CMD_UV_FAULT_ACTION, 16'h0096);
    // Write then read on back-to-back cycles
    @(negedge clk_i);
    cmd_i = '{1'b1, 1'b1, CMD_UV_FAULT_THRESHOLD, 16'h5A3C};
    @(negedge clk_i);
    cmd_i = '{1'b1, 1'b0, CMD_UV_FAULT_THRESHOLD, 16'h0000};
    @(negedge clk_i);
    cmd_i = '0;
    `CHK("thr_b2b", 16'h5A3C, cmd_rdata_o)
    rdchk("unknown", 8'h46, 16'h0000);
    wr(CMD_UV_FAULT_ACTION, 16'h0000);
    $display("test regs done");
  endtask : t_regs

  // Ignore setting keeps running; compare is unsigned
  task automatic t_ignore();
    wr(CMD_UV_FAULT_THRESHOLD, 16'h8000);
    // Below the threshold only when both are read as unsigned
    level = 16'h7000;
    repeat (20) @(negedge clk_i);
    `CHK("uv_unsigned", 1'b1, uv_level_o)
    level = 16'h1000;
    repeat (60) @(negedge clk_i);
    `CHK("uv_level_o", 1'b1, uv_level_o)
    `CHK("ign_enable", 1'b1, out_enable_o)
    `CHK("ign_fault", 1'b0, uv_fault_o)
    level = 16'hFFFF;
    $display("test ignore done");
  endtask : t_ignore

  task automatic t_hold();
    wr(CMD_UV_FAULT_ACTION, 16'h00C0);
    level = 16'h1000;
    wait_en(1'b0, 30);
    `CHK("hold_fault", 1'b1, uv_fault_o)
    // Frozen clock enable keeps the hold although the supply recovers
    ce_i  = 1'b0;
    level = 16'hFFFF;
    repeat (20) @(negedge clk_i);
    `CHK("ce_freeze", 1'b0, out_enable_o)
    ce_i = 1'b1;
    wait_en(1'b1, 30);
    `CHK("hold_clear", 1'b0, uv_fault_o)
    $display("test hold done");
  endtask : t_hold

  // Every retry code, delay code zero, fault never goes away
  task automatic t_retries();
    int k;
    int ex;
    for (int n = 0; n < 8; n++) begin
      wr(CMD_UV_FAULT_ACTION, 16'h0080 | 16'(n << 3));
      level = 16'h1000;
      lat(k);
      if (n == 0) `CHK("react", 1'b1, k <= 3)
      restarts(300, k);
      ex = (n < 7) ? n : 99;
      k  = (n == 7 && k > 6) ? 99 : k;
      `CHK("restarts", ex, k)
      if (n < 7) `CHK("latched", 1'b0, out_enable_o)
      level = 16'hFFFF;
      if (n == 7) begin
        output_on_i = 1'b0;
        repeat (8) @(negedge clk_i);
        `CHK("cmd_off", 1'b0, out_enable_o)
        output_on_i = 1'b1;
        wait_en(1'b1, 60);
      end else begin
        clr();
      end
    end
    $display("test retries done");
  endtask : t_retries

  // Fresh fault after bit clear or output off still gets the full count; a clear command and a reset follow, their recount unchecked
  task automatic t_clears();
    int k;
    wr(CMD_UV_FAULT_ACTION, 16'h0090);
    for (int m = 0; m < 3; m++) begin
      level = 16'h1000;
      restarts(300, k);
      `CHK("recount", 2, k)
      level = 16'hFFFF;
      repeat (10) @(negedge clk_i);
      fault_bit_clear_i = (m == 0);
      output_on_i       = (m != 1);
      @(negedge clk_i);
      fault_bit_clear_i = 1'b0;
      output_on_i       = 1'b1;
      if (m == 2) wr(CMD_CLEAR_FAULTS, 16'h0000);
      wait_en(1'b1, 60);
    end
    level = 16'h1000;
    repeat (60) @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
    `CHK("rst_clear", 1'b0, uv_fault_o)
    rdchk("act_after_rst", CMD_UV_FAULT_ACTION, 16'h0000);
    level = 16'hFFFF;
    $display("test clears done");
  endtask : t_clears

  // Run-on delay scales as a power of two of the tick period
  task automatic t_delay();
    int k;
    wr(CMD_UV_FAULT_THRESHOLD, 16'h8000);
    for (int c = 0; c < 5; c++) begin
      wr(CMD_UV_FAULT_ACTION, 16'h0040 | 16'(c));
      level = 16'h1000;
      lat(k);
      `CHK("run_on", 1'b1, k >= ((1 << c) - 1) * 8 && k <= (1 << c) * 8 + 12)
      clr();
    end
    $display("test delay done");
  endtask : t_delay

  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    t_regs();
    t_ignore();
    t_hold();
    t_retries();
    t_clears();
    t_delay();
    conclude();
  end
endmodule : tb_top
